// File: shared_parallel_io_port.sv
// one shared parallel io port: direction, output latch and pin-value registers
// plus the per-pin peripheral/port output multiplexers feeding the pad cells
// assumes a simple synchronous register bus on i_sys_clk with single-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module shared_parallel_io_port #(
  parameter int          WIDTH       = parallel_io_pkg::DATA_W,
  parameter logic [15:0] IMPL_MASK   = 16'h00ff,
  // pins whose peripherals can drive and may own the pad; clear bits are input only and never own it
  parameter logic [15:0] OUT_CAPABLE = 16'h00ff
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // register bus
  input  wire logic [1:0]  i_addr,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [15:0] i_wr_data,
  output logic      [15:0] o_rd_data,
  // pad inputs, asynchronous
  input  wire logic [15:0] i_pad_in,
  // analog selection and peripheral side, same clock
  input  wire logic [15:0] i_analog_sel,
  input  wire logic [15:0] i_periph_enable,
  input  wire logic [15:0] i_periph_drive,
  input  wire logic [15:0] i_periph_out,
  // pad cell controls and register views
  output logic      [15:0] o_pad_out,
  output logic      [15:0] o_pad_oe,
  output logic      [15:0] o_pin_direction,
  output logic      [15:0] o_output_latch
);
  // implemented bits; the rest stay disabled and read zero
  localparam logic [15:0] MASK = IMPL_MASK & parallel_io_pkg::DIRECTION_RST;

  // bus decode
  logic [parallel_io_pkg::ADDR_W-1:0] reg_index;
  logic                               wr_direction;
  logic                               wr_latch;
  logic                               wr_pin_value;
  logic                               rd_direction;
  logic                               rd_latch;
  logic                               rd_pin_value;
  logic                               rd_unmapped;
  // register state
  logic [15:0]                        pin_direction_reg;
  logic [15:0]                        output_latch_reg;
  logic [15:0]                        next_direction;
  logic [15:0]                        next_latch;
  // pin-value path
  logic [15:0]                        pin_level;
  logic [15:0]                        digital_level;
  logic [15:0]                        pin_value_reg;
  // read path
  logic [15:0]                        rd_data;
  logic [15:0]                        next_rd_data;
  // pad path
  logic [15:0]                        port_drive;
  logic [15:0]                        mux_out;
  logic [15:0]                        mux_oe;
  logic [15:0]                        pad_out;
  logic [15:0]                        pad_oe;
  logic [15:0]                        next_pad_out;
  logic [15:0]                        next_pad_oe;

  assign reg_index = i_addr;

  // one strobe per register; index 3 is unmapped
  always_comb begin
    wr_direction = 1'b0;
    wr_latch     = 1'b0;
    wr_pin_value = 1'b0;
    rd_direction = 1'b0;
    rd_latch     = 1'b0;
    rd_pin_value = 1'b0;
    rd_unmapped  = 1'b0;
    case (reg_index)
      parallel_io_pkg::ADDR_DIRECTION: begin
        wr_direction = i_wr_en;
        rd_direction = i_rd_en;
      end
      parallel_io_pkg::ADDR_PIN_VALUE: begin
        wr_pin_value = i_wr_en;
        rd_pin_value = i_rd_en;
      end
      parallel_io_pkg::ADDR_LATCH: begin
        wr_latch = i_wr_en;
        rd_latch = i_rd_en;
      end
      default: begin
        // writes fall away, reads return zero
        rd_unmapped = i_rd_en;
      end
    endcase
  end

  // direction group
  always_comb begin
    next_direction = pin_direction_reg;
    if (wr_direction) begin
      next_direction = i_wr_data & MASK;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_direction_reg <= parallel_io_pkg::DIRECTION_RST & MASK;
    end else begin
      pin_direction_reg <= next_direction;
    end
  end

  // latch group; pin-value writes land here, never on the pad directly
  always_comb begin
    next_latch = output_latch_reg;
    if (wr_latch) begin
      next_latch = i_wr_data & MASK;
    end
    if (wr_pin_value) begin
      next_latch = i_wr_data & MASK;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      output_latch_reg <= parallel_io_pkg::LATCH_RST & MASK;
    end else begin
      output_latch_reg <= next_latch;
    end
  end

  // pin-value path: synchronise, then clear analog and unimplemented bits
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_sync
      pin_sync u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_pin     (i_pad_in[g]),
        .o_level   (pin_level[g])
      );
    end
  endgenerate

  assign digital_level = pin_level & ~i_analog_sel;
  // the level stays readable whoever owns the pad
  assign pin_value_reg = digital_level & MASK;

  // read group: registered, holds until the next read
  always_comb begin
    next_rd_data = rd_data;
    if (rd_direction) begin
      next_rd_data = pin_direction_reg;
    end
    if (rd_latch) begin
      next_rd_data = output_latch_reg;
    end
    if (rd_pin_value) begin
      next_rd_data = pin_value_reg;
    end
    if (rd_unmapped) begin
      next_rd_data = parallel_io_pkg::ZERO_WORD;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_data <= parallel_io_pkg::ZERO_WORD;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // per pin multiplexer pair; next values let the pad follow the write edge
  generate
    for (g = 0; g < WIDTH; g++) begin : g_mux
      logic own;
      logic mux_bit;
      logic en_bit;
      assign own = i_periph_enable[g] & i_periph_drive[g]
                 & OUT_CAPABLE[g] & MASK[g];
      always_comb begin
        if (own) begin
          mux_bit = i_periph_out[g];
          en_bit  = 1'b1;
        end else begin
          mux_bit = next_latch[g];
          en_bit  = port_drive[g];
        end
      end
      assign port_drive[g] = ~next_direction[g] & MASK[g];
      assign mux_out[g]    = mux_bit;
      assign mux_oe[g]     = en_bit;
    end
  endgenerate

  // pad data group
  always_comb begin
    next_pad_out = mux_out & MASK;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pad_out <= parallel_io_pkg::ZERO_WORD;
    end else begin
      pad_out <= next_pad_out;
    end
  end

  // pad enable group; all pads released in reset
  always_comb begin
    next_pad_oe = mux_oe;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pad_oe <= parallel_io_pkg::ZERO_WORD;
    end else begin
      pad_oe <= next_pad_oe;
    end
  end

  assign o_rd_data       = rd_data;
  assign o_pad_out       = pad_out;
  assign o_pad_oe        = pad_oe;
  assign o_pin_direction = pin_direction_reg;
  assign o_output_latch  = output_latch_reg;
endmodule : shared_parallel_io_port
`default_nettype wire

// File: parallel_io_pkg.sv
// constants for the shared parallel io port slice
// assumes a 16-bit internal register bus with word addressing by register index
// Summary of operation
// - every implemented pin has a direction bit, an output latch bit and a pin-value bit.
// - direction 1 makes the pin an input with the port driver off, 0 drives it from the latch.
// - after any reset every pin is an input.
// - reading the output latch register returns the latch, not the pins.
// - writing the output latch register updates the latch for the written pins.
// - reading the pin-value register returns the levels on the pins.
// - writing the pin-value register updates the latch exactly as a latch write does.
// - unimplemented bits are disabled and their direction, latch and pin-value bits read zero.
// - while an enabled peripheral drives a pin the port driver is off but the pin stays readable.
// - an enabled peripheral that is not driving leaves the pin to the port latch and direction.
// - per pin two multiplexers pick peripheral or port for pad data and enable, peripheral first.
// - a pin shared only with input functions is a dedicated port pin never overridden.
// - all pins but supply, master clear and primary oscillator are shared with peripherals.
// - pins set as analog inputs read low in the pin-value register.
package parallel_io_pkg;
  localparam int          DATA_W         = 16;
  localparam int          ADDR_W         = 2;
  // register indices
  localparam logic [1:0]  ADDR_DIRECTION = 2'h0;
  localparam logic [1:0]  ADDR_PIN_VALUE = 2'h1;
  localparam logic [1:0]  ADDR_LATCH     = 2'h2;
  // reset values before masking by the implemented set
  localparam logic [15:0] DIRECTION_RST  = 16'hffff;
  localparam logic [15:0] LATCH_RST      = 16'h0000;
  localparam logic [15:0] ZERO_WORD      = 16'h0000;
  localparam int          SYNC_STAGES    = 3;
endpackage : parallel_io_pkg

// File: pin_sync.sv
// three-stage synchroniser for one pad input, change accepted when stages two and three agree
// assumes the pin is asynchronous to i_sys_clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level
);
  localparam int LAST = parallel_io_pkg::SYNC_STAGES - 1;

  logic [parallel_io_pkg::SYNC_STAGES-1:0] stage;
  logic [parallel_io_pkg::SYNC_STAGES-1:0] next_stage;
  logic                                    level;
  logic                                    next_level;

  always_comb begin
    next_stage = {stage[LAST-1:0], i_pin};
    next_level = (stage[LAST] == stage[LAST-1]) ? stage[LAST] : level;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage <= '0;
      level <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  assign o_level = level;
endmodule : pin_sync
`default_nettype wire

// File: shared_parallel_io_port_properties.sv
// pin-level checks of the shared port slice
// assumes one clock and an async low reset
`timescale 1ns/1ps
`default_nettype none
module shared_parallel_io_port_properties #(parameter logic [15:0] IMPL_MASK = 16'h00ff,
  parameter logic [15:0] OUT_CAPABLE = 16'h00ff) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_addr,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [15:0] i_wr_data,
  input wire logic [15:0] o_rd_data,
  input wire logic [15:0] i_analog_sel,
  input wire logic [15:0] i_periph_enable,
  input wire logic [15:0] i_periph_drive,
  input wire logic [15:0] i_periph_out,
  input wire logic [15:0] o_pad_out,
  input wire logic [15:0] o_pad_oe,
  input wire logic [15:0] o_pin_direction,
  input wire logic [15:0] o_output_latch
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic [15:0] own = i_periph_enable & i_periph_drive & OUT_CAPABLE;
  sequence lat_wr; i_wr_en && i_addr inside {2'h1, 2'h2}; endsequence
  lat_write_a: assert property (lat_wr |=>
    o_output_latch == ($past(i_wr_data) & IMPL_MASK)) else $error("bad latch");
  dir_write_a: assert property (i_wr_en && i_addr == 2'h0 |=>
    o_pin_direction == ($past(i_wr_data) & IMPL_MASK)) else $error("bad dir");
  reg_hold_a: assert property (!i_wr_en || i_addr == 2'h3 |=>
    $stable(o_output_latch) && $stable(o_pin_direction)) else $error("reg moved");
  lat_read_a: assert property (i_rd_en && i_addr == 2'h2 |=>
    o_rd_data == $past(o_output_latch)) else $error("bad latch read");
  void_read_a: assert property (i_rd_en && i_addr == 2'h3 |=>
    o_rd_data == 16'h0000) else $error("bad void read");
  analog_low_a: assert property (i_rd_en && i_addr == 2'h1 |=>
    (o_rd_data & $past(i_analog_sel | ~IMPL_MASK)) == 16'h0000) else $error("bad pin read");
  pad_oe_a: assert property (i_rst_n |=>
    o_pad_oe == (($past(own) | ~o_pin_direction) & IMPL_MASK)) else $error("bad oe");
  pad_data_a: assert property (i_rst_n |=> (o_pad_out & o_pad_oe) ==
    ((($past(own) & $past(i_periph_out)) | (~$past(own) & o_output_latch)) & o_pad_oe))
    else $error("bad pad data");
endmodule : shared_parallel_io_port_properties
bind shared_parallel_io_port shared_parallel_io_port_properties #(.IMPL_MASK(IMPL_MASK),
  .OUT_CAPABLE(OUT_CAPABLE)) i_shared_parallel_io_port_properties (.*);
`default_nettype wire

// File: pad_partner.sv
// pad cells: pin level is the driven value or the board level
// assumes i_ext holds the board level of undriven pins
`timescale 1ns/1ps
`default_nettype none
module pad_partner (
  input wire logic [15:0] i_out,
  input wire logic [15:0] i_oe,
  input wire logic [15:0] i_ext,
  output logic [15:0] o_pin
);
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule : pad_partner
`default_nettype wire

// File: tb_shared_parallel_io_port.sv
// self-checking bench of the shared port slice
// assumes pads are looped back through pad_partner
`timescale 1ns/1ps
`default_nettype none
module tb_shared_parallel_io_port;
  logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wd = 16'h0000, an = 16'h0000, pe = 16'h0000, pd = 16'h0000;
  logic [15:0] po = 16'h0000, ext = 16'h0000;
  wire logic [15:0] rdat, pin, pout, poe, dir, lat;
  int miscompares = 0, checks = 0;
  shared_parallel_io_port #(.OUT_CAPABLE(16'h007f)) i_shared_parallel_io_port (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr_en(wr), .i_rd_en(rd),
    .i_wr_data(wd), .o_rd_data(rdat), .i_pad_in(pin), .i_analog_sel(an),
    .i_periph_enable(pe), .i_periph_drive(pd), .i_periph_out(po), .o_pad_out(pout),
    .o_pad_oe(poe), .o_pin_direction(dir), .o_output_latch(lat));
  pad_partner i_pad_partner (.i_out(pout), .i_oe(poe), .i_ext(ext), .o_pin(pin));
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wrr(logic [1:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdr(logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
  endtask : rdr
  task automatic results();
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic t_reset();
    chk("dir", dir, 16'h00ff);
    rdr(parallel_io_pkg::ADDR_DIRECTION);
    chk("dir_rd", rdat, 16'h00ff);
  endtask : t_reset
  task automatic t_regs();
    wrr(parallel_io_pkg::ADDR_LATCH, 16'ha5c3);
    rdr(parallel_io_pkg::ADDR_LATCH);
    chk("lat", rdat, 16'h00c3);
    wrr(parallel_io_pkg::ADDR_PIN_VALUE, 16'h0081);
    wrr(2'h3, 16'hffff);
    rdr(parallel_io_pkg::ADDR_LATCH);
    chk("lat_pv", rdat, 16'h0081);
    chk("lat_q", lat, 16'h0081);
    rdr(2'h3);
    chk("void", rdat, 16'h0000);
  endtask : t_regs
  task automatic t_pins();
    wrr(parallel_io_pkg::ADDR_DIRECTION, 16'hfff0);
    ext <= 16'hff50;
    an <= 16'h0040;
    repeat (6) @(posedge clk);
    rdr(parallel_io_pkg::ADDR_PIN_VALUE);
    chk("pins", rdat, 16'h0011);
  endtask : t_pins
  task automatic t_periph();
    wrr(parallel_io_pkg::ADDR_DIRECTION, 16'h0070);
    pe <= 16'h0083;
    pd <= 16'h0081;
    po <= 16'h007e;
    repeat (6) @(posedge clk);
    chk("oe", poe, 16'h008f);
    chk("out", pout & poe, 16'h0080);
    rdr(parallel_io_pkg::ADDR_PIN_VALUE);
    chk("pins_p", rdat, 16'h0090);
  endtask : t_periph
  task automatic t_rerst();
    @(posedge clk);
    pe <= 16'h0000;
    pd <= 16'h0000;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("dir_rst", dir, 16'h00ff);
    chk("lat_rst", lat, 16'h0000);
    chk("oe_rst", poe, 16'h0000);
    rst_n <= 1'b1;
    rdr(parallel_io_pkg::ADDR_LATCH);
    chk("lat_rst_rd", rdat, 16'h0000);
    repeat (2) @(posedge clk);
    chk("oe_after", poe, 16'h0000);
  endtask : t_rerst
  initial forever #2 clk = ~clk;
  initial begin
    #20000;
    miscompares++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_pins();
    t_periph();
    t_rerst();
    results();
  end
endmodule : tb_shared_parallel_io_port
`default_nettype wire
